// *** design/acc_pkg.sv ***
// package: constants and types for the converter control block
package acc_pkg;
  localparam int RES_W = 12;
  localparam int CH_N = 6;
  localparam logic [4:0] SAMPLE_CYC = 5'h04;
  localparam logic [4:0] CONV_CYC = 5'h0C;
  localparam logic [4:0] TOTAL_CYC = 5'h10;
  localparam logic [6:0] DIV_RST = 7'h00;
  localparam logic [4:0] CNT_RST = 5'h00;
  localparam logic [RES_W-1:0] RES_RST = 12'h000;
  // input source codes
  localparam logic [3:0] SRC_SUP = 4'h1;
  localparam logic [3:0] SRC_SUP2 = 4'h2;
  localparam logic [3:0] SRC_SUP4 = 4'h3;
  localparam logic [3:0] SRC_GS = 4'h5;
  localparam logic [3:0] SRC_GS2 = 4'h6;
  localparam logic [3:0] SRC_GS4 = 4'h7;
  localparam logic [3:0] SRC_REG = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } acc_state_t;

  // one-hot selects towards the analog mux
  typedef struct packed {
    logic [CH_N-1:0] chan;
    logic supply;
    logic supplyHalf;
    logic supplyQuarter;
    logic gain;
    logic gainHalf;
    logic gainQuarter;
    logic regDiv;
    logic ground;
  } acc_insel_t;

  typedef struct packed {
    logic refSupply;
    logic refPin;
    logic refGain;
  } acc_refsel_t;
endpackage : acc_pkg

// *** design/acc_conv_ctrl.sv ***
// converter control: start handshake, busy, clock divide, mux and pin control
// Summary of operation
// (R1) start bit low-high-low starts a conversion; high level holds converter reset
// (R2) busy flag goes 1 once a conversion starts
// (R3) busy flag returns 0 when the conversion ends
// (R4) end of conversion sets request flag; enabled request raises interrupt
// (R5) software may poll busy instead of using the interrupt
// (R6) converter clock is system clock divided by 2^code, code 0..7
// (R7) software keeps converter clock period within 0.5 to 10 us
// (R8) power enable powers the converter; clear it when idle
// (R9) software waits settling time after power enable before starting
// (R10) reference field: 00 supply, 01 external pin, 1x gain stage
// (R11) software enables gain stage or configures ref pin as needed
// (R12) supply or gain-stage reference disconnects external reference pin
// (R13) analog pin assignment disables other functions and overrides direction
// (R14) pull-high removed while pin is an analog input
// (R15) source 0000, 0100, 1100-1111 converts the selected external channel
// (R16) channel codes 0-5 route channels; higher codes float
// (R17) source 1, 2, 3 select supply, half, quarter
// (R18) source 5, 6, 7 select gain stage, half, quarter
// (R19) source 8 selects regulator divider; 9-11 ground
// (R20) internal source disconnects every external channel
// (R21) bandgap gain-stage input disconnects the external gain-stage pin
// (R22) gain-stage select 0 takes pin, 1 takes bandgap
// (R23) conversion is 4 sample plus 12 convert clocks, busy for 16
// (R24) justify bit places result left or right, unused bits zero
// (R25) result registers update no later than busy clear and flag set
module acc_conv_ctrl (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic convStart,
  input wire logic convPowerEnable,
  input wire logic [2:0] convClockDividerSel,
  input wire logic [1:0] referenceSourceSel,
  input wire logic [3:0] inputSourceSel,
  input wire logic [3:0] externalChannelSel,
  input wire logic gainStageInputSel,
  input wire logic resultJustifySel,
  input wire logic [acc_pkg::CH_N-1:0] pinFunctionSelect,
  input wire logic [acc_pkg::CH_N-1:0] portDirectionControl,
  input wire logic [acc_pkg::CH_N-1:0] pullHighEnable,
  input wire logic intEnable,
  input wire logic intFlagClear,
  input wire logic [acc_pkg::RES_W-1:0] coreResult,
  output logic convBusyFlag,
  output logic intRequestFlag,
  output logic intOut,
  output logic [7:0] resultHigh,
  output logic [7:0] resultLow,
  output logic convClockEn,
  output logic coreReset,
  output logic coreSample,
  output logic corePower,
  output acc_pkg::acc_insel_t inputSel,
  output acc_pkg::acc_refsel_t refSel,
  output logic gainPinConnect,
  output logic bandgapConnect,
  output logic [acc_pkg::CH_N-1:0] pinOtherFuncDisable,
  output logic [acc_pkg::CH_N-1:0] pinDirInput,
  output logic [acc_pkg::CH_N-1:0] pinPullHighOn
);

  // external channel is used for these source codes
  function automatic logic isExternal(input logic [3:0] src);
    isExternal = (src == 4'h0) || (src == 4'h4) || (src[3:2] == 2'b11);
  endfunction : isExternal

  acc_pkg::acc_state_t state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [6:0] div_q, div_d;
  logic startPrev_q, startPrev_d;
  logic busy_q, busy_d;
  logic flag_q, flag_d;
  logic [7:0] resHi_q, resHi_d;
  logic [7:0] resLo_q, resLo_d;
  logic tick;
  logic startFall;
  logic done;
  logic [9:0] sampLen_q, sampLen_d;

  // divider: a tick every 2^sel system clocks; held clear while powered down
  // restarted on the start edge so the first sample clock is a full period
  always_comb begin
    div_d = div_q + 7'h01;
    tick = 1'b0;
    if (!convPowerEnable || convStart || startFall) begin // R23
      div_d = acc_pkg::DIV_RST;
    end else if (div_q >= ((7'h01 << convClockDividerSel) - 7'h01)) begin // R6
      div_d = acc_pkg::DIV_RST;
      tick = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_q <= acc_pkg::DIV_RST;
    end else begin
      div_q <= div_d;
    end
  end

  assign startFall = startPrev_q && !convStart; // R1
  assign done = (state_q == acc_pkg::ST_CONVERT) && tick && (cnt_q == acc_pkg::TOTAL_CYC - 5'h01);

  // conversion sequencer: start on falling edge of start bit, high holds reset
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    startPrev_d = convStart;
    busy_d = busy_q;
    flag_d = flag_q;
    resHi_d = resHi_q;
    resLo_d = resLo_q;
    if (intFlagClear) begin
      flag_d = 1'b0;
    end
    if (!convPowerEnable || convStart) begin // R1
      state_d = acc_pkg::ST_IDLE;
      cnt_d = acc_pkg::CNT_RST;
      busy_d = 1'b0;
    end else begin
      unique case (state_q)
        acc_pkg::ST_IDLE: begin
          if (startFall) begin
            state_d = acc_pkg::ST_SAMPLE;
            cnt_d = acc_pkg::CNT_RST;
            busy_d = 1'b1; // R2
          end
        end
        acc_pkg::ST_SAMPLE: begin
          if (tick) begin
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == acc_pkg::SAMPLE_CYC - 5'h01) begin // R23
              state_d = acc_pkg::ST_CONVERT;
            end
          end
        end
        acc_pkg::ST_CONVERT: begin
          if (tick) begin
            cnt_d = cnt_q + 5'h01;
          end
          if (done) begin // R23
            state_d = acc_pkg::ST_IDLE;
            busy_d = 1'b0; // R3
            flag_d = 1'b1; // R4
            // result lands in the same cycle busy clears
            if (resultJustifySel) begin // R24 R25
              resHi_d = {4'h0, coreResult[11:8]};
              resLo_d = coreResult[7:0];
            end else begin
              resHi_d = coreResult[11:4];
              resLo_d = {coreResult[3:0], 4'h0};
            end
          end
        end
        default: begin
          state_d = acc_pkg::ST_IDLE;
          busy_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= acc_pkg::ST_IDLE;
      cnt_q <= acc_pkg::CNT_RST;
      startPrev_q <= 1'b0;
      busy_q <= 1'b0;
      flag_q <= 1'b0;
      resHi_q <= acc_pkg::RES_RST[7:0];
      resLo_q <= acc_pkg::RES_RST[7:0];
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      startPrev_q <= startPrev_d;
      busy_q <= busy_d;
      flag_q <= flag_d;
      resHi_q <= resHi_d;
      resLo_q <= resLo_d;
    end
  end

  assign convBusyFlag = busy_q; // R5
  assign intRequestFlag = flag_q;
  assign intOut = flag_q && intEnable; // R4
  assign resultHigh = resHi_q;
  assign resultLow = resLo_q;
  assign convClockEn = tick;
  assign coreReset = convStart; // R1
  assign coreSample = (state_q == acc_pkg::ST_SAMPLE);
  assign corePower = convPowerEnable; // R8

  // analog input mux decode
  always_comb begin
    inputSel = '0;
    if (isExternal(inputSourceSel)) begin // R15 R20
      if (externalChannelSel < 4'h6) begin // R16
        inputSel.chan[externalChannelSel[2:0]] = 1'b1;
      end
    end else begin
      unique case (inputSourceSel)
        acc_pkg::SRC_SUP: inputSel.supply = 1'b1; // R17
        acc_pkg::SRC_SUP2: inputSel.supplyHalf = 1'b1;
        acc_pkg::SRC_SUP4: inputSel.supplyQuarter = 1'b1;
        acc_pkg::SRC_GS: inputSel.gain = 1'b1; // R18
        acc_pkg::SRC_GS2: inputSel.gainHalf = 1'b1;
        acc_pkg::SRC_GS4: inputSel.gainQuarter = 1'b1;
        acc_pkg::SRC_REG: inputSel.regDiv = 1'b1; // R19
        default: inputSel.ground = 1'b1; // R19
      endcase
    end
  end

  // reference select; the pin only connects for code 01
  always_comb begin
    refSel.refSupply = (referenceSourceSel == 2'b00); // R10
    refSel.refPin = (referenceSourceSel == 2'b01); // R12
    refSel.refGain = referenceSourceSel[1];
  end

  assign gainPinConnect = !gainStageInputSel; // R21 R22
  assign bandgapConnect = gainStageInputSel; // R22

  // analog pins: other functions off, direction forced to input, pull-high off
  assign pinOtherFuncDisable = pinFunctionSelect; // R13
  assign pinDirInput = pinFunctionSelect | portDirectionControl; // R13
  assign pinPullHighOn = pullHighEnable & ~pinFunctionSelect; // R14

  // sample-phase length in system clocks; only the sample length check reads it
  always_comb begin
    sampLen_d = coreSample ? sampLen_q + 10'h001 : 10'h000;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sampLen_q <= 10'h000;
    end else begin
      sampLen_q <= sampLen_d;
    end
  end

  // sequencer and handshake checks
  a_busy_on_start: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    startFall && convPowerEnable && state_q == acc_pkg::ST_IDLE |=> convBusyFlag)
    else $error("busy not set after start");
  a_busy_clear_done: assert property (@(posedge mclk) disable iff (!rst_n) // R3
    done |=> !convBusyFlag && intRequestFlag)
    else $error("busy not cleared or flag not set at end");
  a_int_gate: assert property (@(posedge mclk) disable iff (!rst_n) // R4
    intOut |-> intRequestFlag && intEnable)
    else $error("interrupt without enabled flag");
  a_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_n) // R4
    intRequestFlag && !intFlagClear |=> intRequestFlag)
    else $error("request flag dropped without clear");
  a_start_reset: assert property (@(posedge mclk) disable iff (!rst_n) // R1
    convStart |=> !convBusyFlag)
    else $error("busy while start held");
  a_busy_power: assert property (@(posedge mclk) disable iff (!rst_n) // R8
    !convPowerEnable |=> !convBusyFlag)
    else $error("busy while powered down");
  a_sample_busy: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    coreSample |-> convBusyFlag)
    else $error("sampling without busy");
  a_sample_len: assert property (@(posedge mclk) disable iff (!rst_n) // R23
    $fell(coreSample) && state_q == acc_pkg::ST_CONVERT
    |-> sampLen_q == (10'(acc_pkg::SAMPLE_CYC) << convClockDividerSel))
    else $error("sample phase not four converter clocks");
  a_cnt_range: assert property (@(posedge mclk) disable iff (!rst_n) // R23
    state_q != acc_pkg::ST_IDLE |-> cnt_q < acc_pkg::TOTAL_CYC)
    else $error("converter cycle count out of range");

  // divider and result checks
  a_tick_gap: assert property (@(posedge mclk) disable iff (!rst_n) // R6
    convClockEn |=> !convClockEn || convClockDividerSel == 3'h0)
    else $error("converter clock enable longer than one cycle");
  a_res_hold: assert property (@(posedge mclk) disable iff (!rst_n) // R25
    !done |=> $stable(resultHigh) && $stable(resultLow))
    else $error("result changed outside end of conversion");
  a_just_right: assert property (@(posedge mclk) disable iff (!rst_n) // R24
    done && resultJustifySel |=> resultHigh[7:4] == 4'h0)
    else $error("right justify upper bits not zero");

  // mux and pin checks
  a_ext_disc: assert property (@(posedge mclk) disable iff (!rst_n) // R20
    !isExternal(inputSourceSel) |-> inputSel.chan == '0)
    else $error("external channel connected with internal source");
  a_insel_onehot: assert property (@(posedge mclk) disable iff (!rst_n) // R16
    $onehot0(inputSel))
    else $error("more than one converter input selected");
  a_ref_pin: assert property (@(posedge mclk) disable iff (!rst_n) // R12
    referenceSourceSel != 2'b01 |-> !refSel.refPin)
    else $error("reference pin not disconnected");
  a_ref_onehot: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    $onehot(refSel))
    else $error("reference select not exactly one source");
  a_gain_sel: assert property (@(posedge mclk) disable iff (!rst_n) // R21
    gainStageInputSel |-> bandgapConnect && !gainPinConnect)
    else $error("gain-stage pin still connected with bandgap input");
  a_pin_dir: assert property (@(posedge mclk) disable iff (!rst_n) // R13
    (pinDirInput & pinFunctionSelect) == pinFunctionSelect)
    else $error("analog pin direction not forced to input");
  a_pull_off: assert property (@(posedge mclk) disable iff (!rst_n) // R14
    (pinPullHighOn & pinFunctionSelect) == '0)
    else $error("pull-high on analog pin");

endmodule : acc_conv_ctrl

// *** testbench/acc_core_model.sv ***
// analog core stand-in: latches the applied level while sampling
module acc_core_model (
  input wire logic mclk,
  input wire logic corePower,
  input wire logic coreSample,
  input wire logic [11:0] level,
  output logic [11:0] coreResult
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] held = 12'h000;
  // an unpowered core shows a changing pattern, never its last value
  always @(posedge mclk) begin
    if (coreSample) held <= level;
    else if (!corePower) held <= ~held;
  end
  assign coreResult = held;
endmodule : acc_core_model

// *** testbench/tb_acc_conv_ctrl.sv ***
// self-checking bench for the converter control block
module tb_acc_conv_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst_n = 0, start = 0, pwr = 0, gsel = 0, just = 0, ie = 0, fclr = 0;
  logic [2:0] div = 3'h0;
  logic [1:0] rsel = 2'h0;
  logic [3:0] src = 4'h0, ch = 4'h0;
  logic [5:0] pfs = 6'h00, dir = 6'h00, pull = 6'h00, pod, pdi, ppo;
  logic [11:0] level = 12'h000, res;
  logic busy, flag, irq, cke, crst, csmp, cpwr, gpin, bgc;
  logic [7:0] rh, rl;
  acc_pkg::acc_insel_t isel;
  acc_pkg::acc_refsel_t refs;
  int mismatches = 0, cmp_count = 0;

  // free-running system clock
  always #20 mclk = ~mclk;

  acc_conv_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .convStart(start), .convPowerEnable(pwr),
    .convClockDividerSel(div), .referenceSourceSel(rsel), .inputSourceSel(src),
    .externalChannelSel(ch), .gainStageInputSel(gsel), .resultJustifySel(just),
    .pinFunctionSelect(pfs), .portDirectionControl(dir), .pullHighEnable(pull),
    .intEnable(ie), .intFlagClear(fclr), .coreResult(res), .convBusyFlag(busy),
    .intRequestFlag(flag), .intOut(irq), .resultHigh(rh), .resultLow(rl),
    .convClockEn(cke), .coreReset(crst), .coreSample(csmp), .corePower(cpwr),
    .inputSel(isel), .refSel(refs), .gainPinConnect(gpin), .bandgapConnect(bgc),
    .pinOtherFuncDisable(pod), .pinDirInput(pdi), .pinPullHighOn(ppo));

  acc_core_model core_u (.mclk(mclk), .corePower(cpwr), .coreSample(csmp),
    .level(level), .coreResult(res));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // expected one-hot mux select; unknown channel codes leave it all zero
  function automatic acc_pkg::acc_insel_t expsel(input logic [3:0] s, input logic [3:0] c);
    acc_pkg::acc_insel_t e;
    e = '0;
    if (s == 4'h0 || s == 4'h4 || s >= 4'hC) begin
      if (c < 4'h6) e.chan[c] = 1'b1;
    end
    else if (s == 4'h1) e.supply = 1'b1;
    else if (s == 4'h2) e.supplyHalf = 1'b1;
    else if (s == 4'h3) e.supplyQuarter = 1'b1;
    else if (s == 4'h5) e.gain = 1'b1;
    else if (s == 4'h6) e.gainHalf = 1'b1;
    else if (s == 4'h7) e.gainQuarter = 1'b1;
    else if (s == 4'h8) e.regDiv = 1'b1;
    else e.ground = 1'b1;
    return e;
  endfunction : expsel

  // one full conversion: busy length, flag, interrupt, result layout, flag clear
  task automatic t_conv(input logic [2:0] d, input logic j, input logic e, input logic [11:0] v);
    int n;
    int ticks;
    @(posedge mclk);
    div <= d;
    just <= j;
    ie <= e;
    level <= v;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    @(posedge mclk);
    #1;
    check(busy, 1'b1);
    check(csmp, 1'b1);
    n = 0;
    ticks = 0;
    // poll busy as software would with the interrupt unused
    while (busy === 1'b1 && n < 9000) begin
      n++;
      if (cke === 1'b1) ticks++;
      @(posedge mclk);
      #1;
    end
    check(16'(n), 16'(acc_pkg::TOTAL_CYC) << d);
    check(16'(ticks), 16'(acc_pkg::TOTAL_CYC));
    check(busy, 1'b0);
    check(flag, 1'b1);
    check(irq, e);
    check({rh, rl}, j ? {4'h0, v} : {v, 4'h0});
    @(posedge mclk);
    fclr <= 1'b1;
    @(posedge mclk);
    fclr <= 1'b0;
    #1;
    check(flag, 1'b0);
    check(irq, 1'b0);
  endtask : t_conv

  // a new high start aborts; busy stays clear with power off
  task automatic t_abort;
    @(posedge mclk);
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    repeat (5) @(posedge mclk);
    start <= 1'b1;
    @(posedge mclk);
    #1;
    check(busy, 1'b0);
    check(crst, 1'b1);
    repeat (20) @(posedge mclk);
    #1;
    check(flag, 1'b0);
    @(posedge mclk);
    start <= 1'b0;
    pwr <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    check(busy, 1'b0);
    check(cpwr, 1'b0);
    @(posedge mclk);
    pwr <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : t_abort

  // every source code against every channel code
  task automatic t_mux;
    for (int s = 0; s < 16; s++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge mclk);
        src <= s[3:0];
        ch <= c[3:0];
        #1;
        check(isel, expsel(s[3:0], c[3:0]));
      end
    end
  endtask : t_mux

  // reference codes, gain-stage input and per-pin overrides
  task automatic t_pins;
    // gain-stage enable and reference pin setup sit outside this block
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      rsel <= k[1:0];
      gsel <= k[0];
      pfs <= 6'h2D >> k;
      dir <= 6'h16 << k;
      pull <= 6'h3F >> k;
      #1;
      check(refs, {k == 0, k == 1, k >= 2});
      check(gpin, !gsel);
      check(bgc, gsel);
      check(pod, pfs);
      check(pdi, pfs | dir);
      check(ppo, pull & ~pfs);
    end
  endtask : t_pins

  // main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    pwr <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    check(busy, 1'b0);
    // at 40 ns only divider codes 4 to 7 keep the converter clock in range
    t_conv(3'h4, 1'b0, 1'b1, 12'hA5C);
    t_conv(3'h5, 1'b1, 1'b0, 12'h3E7);
    t_abort();
    t_mux();
    t_pins();
    end_sim();
  end

  // watchdog: the whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    end_sim();
  end
endmodule : tb_acc_conv_ctrl
